// *** core/cped_pkg.sv ***
// Purpose: Shared constants for the cache performance event decoder.
// Assumes: Registers sit on a 32-bit classic Wishbone slave, one word each.
// Notes: Line state codes match the encoding of every line state port of the event sources.

package cped_pkg;

  // ------------------------------------------------------------------
  // Register map and fields
  // ------------------------------------------------------------------
  localparam logic [7:0] CPED_OFF_CTRL = 8'h00;
  localparam logic [7:0] CPED_OFF_COUNT = 8'h04;
  localparam logic [7:0] CPED_OFF_STATUS = 8'h08;
  localparam int CPED_CTRL_EV_LSB = 0;
  localparam int CPED_CTRL_UM_LSB = 8;
  localparam int CPED_CTRL_EN_BIT = 16;
  localparam int CPED_STAT_SUP_BIT = 0;
  localparam int CPED_STAT_HALT_BIT = 1;
  localparam logic [7:0] CPED_EV_RST = 8'h00;
  localparam logic [7:0] CPED_UM_RST = 8'h00;
  localparam logic CPED_EN_RST = 1'b0;
  localparam logic [31:0] CPED_COUNT_RST = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Event numbers
  // ------------------------------------------------------------------
  localparam logic [7:0] CPED_EV_L2_DATA = 8'h26;
  localparam logic [7:0] CPED_EV_L2_OWN = 8'h27;
  localparam logic [7:0] CPED_EV_L1_WB = 8'h28;
  localparam logic [7:0] CPED_EV_LLC = 8'h2e;
  localparam logic [7:0] CPED_EV_UNHALTED = 8'h3c;

  // ------------------------------------------------------------------
  // Unit masks and line states
  // ------------------------------------------------------------------
  localparam logic [3:0] CPED_NIB_ALL = 4'hf;
  localparam logic [3:0] CPED_NIB_HIT = 4'he;
  localparam logic [7:0] CPED_UM_DATA_ALL = 8'hff;
  localparam logic [7:0] CPED_UM_STORE_E = 8'h04;
  localparam logic [7:0] CPED_UM_LLC_REF = 8'h4f;
  localparam logic [7:0] CPED_UM_LLC_MISS = 8'h41;
  localparam logic [7:0] CPED_UM_CYCLES = 8'h00;
  localparam logic [1:0] CPED_ST_I = 2'h0;
  localparam logic [1:0] CPED_ST_S = 2'h1;
  localparam logic [1:0] CPED_ST_E = 2'h2;
  localparam logic [1:0] CPED_ST_M = 2'h3;

endpackage

// *** core/cped_top.sv ***
// Purpose: Event selection decoder and counter for cache performance events.
// Assumes: Event sources run on CLK_SYS and pulse at most once per cycle.
// Notes: The increment lands two cycles after the qualifying source cycle, one cycle after EVT_HIT.
//
// Contract
// - Event 26H mask 80H counts prefetch data loads to modified lines.
// - Event 26H mask F0H counts every L2 prefetch request.
// - Event 26H mask FFH counts every L2 data request.
// - Event 27H mask 01H counts store ownership requests missing the L2.
// - Event 27H masks 02H and 08H count store hits on shared, modified.
// - Event 27H mask 0EH counts store requests on shared/exclusive/modified.
// - Event 27H mask 0FH counts every store ownership request.
// - Ownership events count demand requests only, never prefetches.
// - Event 27H masks 10H-80H count lock requests by line state.
// - Event 27H mask E0H counts lock requests hitting a valid line.
// - Event 27H mask F0H counts every lock ownership request.
// - Event 28H masks 01H-08H count L1 writebacks by line state.
// - Event 28H mask 0FH counts every L1 writeback.
// - Event 2EH mask 4FH counts core LLC references, not prefetch fills.
// - Event 2EH mask 41H counts LLC misses, not prefetch fills.
// - Event 3CH mask 00H counts cycles outside the halt state.
//
// Implementation choices: the placing of the registers and the Wishbone register port.

`timescale 1ns/1ps
`default_nettype none

module cped_top
  import cped_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic L2_DATA_VALID,
  input wire logic L2_DATA_PREFETCH,
  input wire logic [1:0] L2_DATA_STATE,
  input wire logic L2_OWN_VALID,
  input wire logic L2_OWN_PREFETCH,
  input wire logic L2_OWN_LOCK,
  input wire logic [1:0] L2_OWN_STATE,
  input wire logic L1_WB_VALID,
  input wire logic [1:0] L1_WB_STATE,
  input wire logic LLC_REF_VALID,
  input wire logic LLC_REF_MISS,
  input wire logic LLC_REF_HW_PREFETCH,
  input wire logic HALT_INSTRUCTION_DONE,
  input wire logic THREAD_WAKE,
  output logic EVT_HIT
);

  // ------------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------------
  // The counter is read through one 32-bit word, so it cannot be wider.
  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must lie between 1 and 32");
  end

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [7:0] ctrl_ev;
  logic [7:0] ctrl_um;
  logic ctrl_en;
  logic [CNT_W-1:0] count;
  logic halted;
  logic supported;
  logic next_hit;
  logic [31:0] byte_mask;
  logic [7:0] word_adr;
  logic req;
  logic wr_now;
  logic [31:0] count_word;
  logic [31:0] next_count_word;
  logic [31:0] next_rdata;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  // Byte enables expand into a bit mask, one lane per generate step.
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign byte_mask[8*i +: 8] = {8{WB_SEL_I[i]}};
  end

  // The write lands on the edge where the master sees ack high.
  assign word_adr = {WB_ADR_I[7:2], 2'b00};
  assign req = WB_CYC_I && WB_STB_I;
  assign wr_now = req && WB_WE_I && WB_ACK_O;
  assign count_word = 32'(count);

  // ------------------------------------------------------------------
  // Selection checks
  // ------------------------------------------------------------------
  // A state nibble is valid as a single state, all states, or the three hit states when allow_hit is set.
  function automatic logic cped_nib_ok(input logic [3:0] n, input logic allow_hit);
    logic ok;
    ok = (n != 4'h0) && ((n & 4'(n - 4'h1)) == 4'h0);
    ok = ok || (n == CPED_NIB_ALL) || (allow_hit && n == CPED_NIB_HIT);
    return ok;
  endfunction

  // Only the listed pairs of event and mask count; anything else holds still.
  function automatic logic cped_supported(input logic [7:0] ev, input logic [7:0] um);
    logic ok;
    ok = 1'b0;
    case (ev)
      CPED_EV_L2_DATA: begin
        ok = (um[7:4] == 4'h0 && cped_nib_ok(um[3:0], 1'b0))
          || (um[3:0] == 4'h0 && cped_nib_ok(um[7:4], 1'b0))
          || (um == CPED_UM_DATA_ALL);
      end
      CPED_EV_L2_OWN: begin
        // The exclusive store mask alone is not offered.
        ok = (um[7:4] == 4'h0 && cped_nib_ok(um[3:0], 1'b1) && um != CPED_UM_STORE_E)
          || (um[3:0] == 4'h0 && cped_nib_ok(um[7:4], 1'b1));
      end
      CPED_EV_L1_WB: begin
        ok = um[7:4] == 4'h0 && cped_nib_ok(um[3:0], 1'b0);
      end
      CPED_EV_LLC: begin
        ok = (um == CPED_UM_LLC_REF) || (um == CPED_UM_LLC_MISS);
      end
      CPED_EV_UNHALTED: begin
        ok = (um == CPED_UM_CYCLES);
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  assign supported = cped_supported(ctrl_ev, ctrl_um);

  // ------------------------------------------------------------------
  // Event decode
  // ------------------------------------------------------------------
  // The low nibble selects demand or store states, the high nibble
  // prefetch or lock states, indexed by {kind, state}.
  always_comb begin
    next_hit = 1'b0;
    if (ctrl_en && supported) begin
      case (ctrl_ev)
        CPED_EV_L2_DATA: begin
          next_hit = L2_DATA_VALID && ctrl_um[{L2_DATA_PREFETCH, L2_DATA_STATE}];
        end
        CPED_EV_L2_OWN: begin
          // Prefetch ownership requests are dropped outright.
          next_hit = L2_OWN_VALID && !L2_OWN_PREFETCH
            && ctrl_um[{L2_OWN_LOCK, L2_OWN_STATE}];
        end
        CPED_EV_L1_WB: begin
          next_hit = L1_WB_VALID && ctrl_um[{1'b0, L1_WB_STATE}];
        end
        CPED_EV_LLC: begin
          // Fills from the L2 hardware prefetcher never count.
          next_hit = LLC_REF_VALID && !LLC_REF_HW_PREFETCH
            && (ctrl_um == CPED_UM_LLC_REF || LLC_REF_MISS);
        end
        CPED_EV_UNHALTED: begin
          next_hit = !halted;
        end
        default: begin
          next_hit = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Halt tracking
  // ------------------------------------------------------------------
  // The cycle that retires the halt still counts; entry wins over a wake
  // in the same cycle so that a halt is never missed.
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      halted <= 1'b0;
    end else if (HALT_INSTRUCTION_DONE) begin
      halted <= 1'b1;
    end else if (THREAD_WAKE) begin
      halted <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      ctrl_ev <= CPED_EV_RST;
      ctrl_um <= CPED_UM_RST;
      ctrl_en <= CPED_EN_RST;
    end else if (wr_now && word_adr == CPED_OFF_CTRL) begin
      if (WB_SEL_I[0]) begin
        ctrl_ev <= WB_DAT_I[CPED_CTRL_EV_LSB +: 8];
      end
      if (WB_SEL_I[1]) begin
        ctrl_um <= WB_DAT_I[CPED_CTRL_UM_LSB +: 8];
      end
      if (WB_SEL_I[2]) begin
        ctrl_en <= WB_DAT_I[CPED_CTRL_EN_BIT];
      end
    end
  end

  // ------------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------------
  // A software load adds the increment of the same cycle, so no event
  // is lost to a write.
  assign next_count_word = (count_word & ~byte_mask) | (WB_DAT_I & byte_mask);

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      count <= CNT_W'(CPED_COUNT_RST);
    end else if (wr_now && word_adr == CPED_OFF_COUNT) begin
      count <= CNT_W'(next_count_word) + CNT_W'(EVT_HIT);
    end else begin
      count <= count + CNT_W'(EVT_HIT);
    end
  end

  // The hit pulse is registered so the output comes from a flip-flop.
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      EVT_HIT <= 1'b0;
    end else begin
      EVT_HIT <= next_hit;
    end
  end

  // ------------------------------------------------------------------
  // Bus answer
  // ------------------------------------------------------------------
  // Unmapped words read as zero and ignore writes.
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (word_adr)
      CPED_OFF_CTRL: begin
        next_rdata[CPED_CTRL_EV_LSB +: 8] = ctrl_ev;
        next_rdata[CPED_CTRL_UM_LSB +: 8] = ctrl_um;
        next_rdata[CPED_CTRL_EN_BIT] = ctrl_en;
      end
      CPED_OFF_COUNT: begin
        next_rdata = count_word;
      end
      CPED_OFF_STATUS: begin
        next_rdata[CPED_STAT_SUP_BIT] = supported;
        next_rdata[CPED_STAT_HALT_BIT] = halted;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // Ack follows one cycle after the request and drops the cycle after.
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= req && !WB_ACK_O;
      if (req && !WB_ACK_O) begin
        WB_DAT_O <= next_rdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cped_cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  chk_pf_modified_step: assert property (
    ctrl_en && ctrl_ev == CPED_EV_L2_DATA && ctrl_um == 8'h80 && L2_DATA_VALID
      && L2_DATA_PREFETCH && L2_DATA_STATE == CPED_ST_M && !wr_now
    |=> EVT_HIT ##1 (count == $past(count) + CNT_W'(1)
      || $past(wr_now && word_adr == CPED_OFF_COUNT)))
    else $error("prefetch modified load not counted");

  chk_pf_all_demand: assert property (
    ctrl_en && ctrl_ev == CPED_EV_L2_DATA && ctrl_um == 8'hf0 && L2_DATA_VALID
    |=> EVT_HIT == $past(L2_DATA_PREFETCH))
    else $error("prefetch all mask miscounts");

  chk_data_any: assert property (
    ctrl_en && ctrl_ev == CPED_EV_L2_DATA && ctrl_um == 8'hff
    |=> EVT_HIT == $past(L2_DATA_VALID))
    else $error("all data requests miscounted");

  chk_store_miss: assert property (
    ctrl_en && ctrl_ev == CPED_EV_L2_OWN && ctrl_um == 8'h01 && L2_OWN_VALID
      && !L2_OWN_LOCK && !L2_OWN_PREFETCH
    |=> EVT_HIT == ($past(L2_OWN_STATE) == CPED_ST_I))
    else $error("store ownership miss miscounted");

  chk_store_hit_set: assert property (
    ctrl_en && ctrl_ev == CPED_EV_L2_OWN && ctrl_um == 8'h0e && L2_OWN_VALID
      && !L2_OWN_LOCK && !L2_OWN_PREFETCH
    |=> EVT_HIT != ($past(L2_OWN_STATE) == CPED_ST_I))
    else $error("store ownership hit miscounted");

  chk_store_demand: assert property (
    ctrl_ev == CPED_EV_L2_OWN && L2_OWN_PREFETCH && !L1_WB_VALID
    |=> !EVT_HIT)
    else $error("ownership prefetch was counted");

  chk_lock_all: assert property (
    ctrl_en && ctrl_ev == CPED_EV_L2_OWN && ctrl_um == 8'hf0 && !L2_OWN_PREFETCH
    |=> EVT_HIT == $past(L2_OWN_VALID && L2_OWN_LOCK))
    else $error("lock ownership requests miscounted");

  chk_wb_all: assert property (
    ctrl_en && ctrl_ev == CPED_EV_L1_WB && ctrl_um == 8'h0f
    |=> EVT_HIT == $past(L1_WB_VALID))
    else $error("writebacks miscounted");

  chk_llc_no_pf_fill: assert property (
    ctrl_ev == CPED_EV_LLC && LLC_REF_HW_PREFETCH |=> !EVT_HIT)
    else $error("prefetch fill counted as reference");

  chk_unhalted_halt: assert property (
    ctrl_en && ctrl_ev == CPED_EV_UNHALTED && ctrl_um == 8'h00
      && HALT_INSTRUCTION_DONE ##1 ctrl_en && ctrl_ev == CPED_EV_UNHALTED
    |=> !EVT_HIT)
    else $error("halted cycle counted");

  chk_unsupported_idle: assert property (
    !ctrl_en || !supported |=> !EVT_HIT)
    else $error("count moved for unsupported selection");

endmodule

`default_nettype wire

// *** verif/cped_src_model.sv ***
// Purpose: Event source model standing in for the cache hierarchy and pipeline.
// Assumes: Sources change just after the rising edge of clk.
// Notes: Prefetch ownership requests appear only while allow_own_pf is set.

`timescale 1ns/1ps
`default_nettype none

module cped_src_model (
  input wire logic clk,
  input wire logic run,
  input wire logic allow_own_pf,
  output logic dv,
  output logic dp,
  output logic [1:0] ds,
  output logic ov,
  output logic op,
  output logic ol,
  output logic [1:0] os,
  output logic wv,
  output logic [1:0] ws,
  output logic lv,
  output logic lm,
  output logic lp,
  output logic halt,
  output logic wake
);
  logic run_q;

  // ------------------------------------------------------------------
  // Traffic
  // ------------------------------------------------------------------
  // All sources start quiet so that nothing qualifies before the first run.
  initial begin
    {run_q, dv, dp, ds, ov, op, ol, os, wv, ws, lv, lm, lp, halt, wake} = '0;
  end

  // Random traffic while running; a closing halt pulse parks the thread so
  // that even the cycle event stays quiet during register accesses.
  always @(posedge clk) begin
    run_q <= run;
    {dv, dp, ds} <= run ? 4'($urandom) : 4'h0;
    {ov, ol, os} <= run ? 4'($urandom) : 4'h0;
    op <= run & allow_own_pf & 1'($urandom);
    {wv, ws} <= run ? 3'($urandom) : 3'h0;
    {lv, lm, lp} <= run ? 3'($urandom) : 3'h0;
    halt <= run ? ($urandom % 8 == 0) : (run_q & !run);
    wake <= run ? ($urandom % 4 == 0) : 1'b0;
  end
endmodule

`default_nettype wire

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench for the cache performance event decoder.
// Assumes: Wishbone answers with a registered ack; sources sampled each edge.
// Notes: Expected hits are predicted one cycle ahead from the sampled sources.

`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import cped_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, cnt_exp = 32'h0, base;
  logic ack, hit, run = 1'b0, allow = 1'b0, halted = 1'b0, pred_q = 1'b0;
  logic dv, dp, ov, op, ol, wv, lv, lm, lp, halt, wake;
  logic [1:0] ds, os, ws;
  logic [7:0] cur_ev = 8'h00, cur_um = 8'h00;
  logic cur_en = 1'b0;
  int fails = 0;
  int checked = 0;
  logic [16:0] sels [$] = '{17'h1_8026, 17'h1_f026, 17'h1_ff26, 17'h1_0126, 17'h1_1026,
    17'h1_0127, 17'h1_0227, 17'h1_0827, 17'h1_0e27, 17'h1_0f27, 17'h1_1027, 17'h1_2027,
    17'h1_4027, 17'h1_8027, 17'h1_e027, 17'h1_f027, 17'h1_0427, 17'h1_0128, 17'h1_0228,
    17'h1_0428, 17'h1_0828, 17'h1_0f28, 17'h1_4f2e, 17'h1_412e, 17'h1_003c,
    17'h0_ff26, 17'h1_0129};

  always #12.5 clk = ~clk;

  cped_top i_dut (.CLK_SYS(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .L2_DATA_VALID(dv), .L2_DATA_PREFETCH(dp), .L2_DATA_STATE(ds),
    .L2_OWN_VALID(ov), .L2_OWN_PREFETCH(op), .L2_OWN_LOCK(ol), .L2_OWN_STATE(os),
    .L1_WB_VALID(wv), .L1_WB_STATE(ws), .LLC_REF_VALID(lv), .LLC_REF_MISS(lm),
    .LLC_REF_HW_PREFETCH(lp), .HALT_INSTRUCTION_DONE(halt), .THREAD_WAKE(wake),
    .EVT_HIT(hit));

  cped_src_model i_src (.clk(clk), .run(run), .allow_own_pf(allow), .dv(dv), .dp(dp),
    .ds(ds), .ov(ov), .op(op), .ol(ol), .os(os), .wv(wv), .ws(ws), .lv(lv), .lm(lm),
    .lp(lp), .halt(halt), .wake(wake));

  // ------------------------------------------------------------------
  // Prediction
  // ------------------------------------------------------------------
  function automatic logic sup(input logic [7:0] ev, input logic [7:0] um);
    case (ev)
      CPED_EV_L2_DATA: return um inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h0f, 8'h10,
                                         8'h20, 8'h40, 8'h80, 8'hf0, 8'hff};
      CPED_EV_L2_OWN: return um inside {8'h01, 8'h02, 8'h08, 8'h0e, 8'h0f, 8'h10,
                                        8'h20, 8'h40, 8'h80, 8'he0, 8'hf0};
      CPED_EV_L1_WB: return um inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h0f};
      CPED_EV_LLC: return um inside {CPED_UM_LLC_REF, CPED_UM_LLC_MISS};
      CPED_EV_UNHALTED: return um == CPED_UM_CYCLES;
      default: return 1'b0;
    endcase
  endfunction

  // Unit mask bit index is the request kind above the line state.
  function automatic logic pred();
    if (!cur_en || !sup(cur_ev, cur_um)) return 1'b0;
    case (cur_ev)
      CPED_EV_L2_DATA: return dv & cur_um[{dp, ds}];
      CPED_EV_L2_OWN: return ov & !op & cur_um[{ol, os}];
      CPED_EV_L1_WB: return wv & cur_um[{1'b0, ws}];
      CPED_EV_LLC: return lv & !lp & (lm | (cur_um == CPED_UM_LLC_REF));
      default: return !halted;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 4'h0, 32'h0, r);
    check(r, e);
  endtask

  // Every cycle the hit flag must match the prediction from the last edge.
  always @(posedge clk) begin
    if (rst_n) begin
      check(32'(hit), 32'(pred_q));
      cnt_exp <= cnt_exp + 32'(pred());
      pred_q <= pred();
      if (halt) halted <= 1'b1;
      else if (wake) halted <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [31:0] pre;
    void'($urandom(32'he1ab));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(CPED_OFF_CTRL, 32'h0);
    rd_chk(CPED_OFF_COUNT, 32'h0);
    rd_chk(CPED_OFF_STATUS, 32'h0);
    rd_chk(8'h0c, 32'h0);
    wb(1'b1, CPED_OFF_CTRL, 4'hf, 32'h0001_4f2e, r);
    wb(1'b1, CPED_OFF_CTRL, 4'h2, 32'hffff_41ff, r);
    rd_chk(CPED_OFF_CTRL, 32'h0001_412e);
    // Each selection runs random traffic; 27H/04 and 29H must stay silent.
    // The counter starts from a random preload so that stale bits would show.
    // The predictor's selection follows the design's register on the same edge,
    // so it is updated by a non-blocking assignment at the write's ack edge.
    foreach (sels[i]) begin
      pre = $urandom;
      wb(1'b1, CPED_OFF_COUNT, 4'hf, pre, r);
      base = cnt_exp - pre;
      wb(1'b1, CPED_OFF_CTRL, 4'hf, 32'(sels[i]), r);
      {cur_en, cur_um, cur_ev} <= sels[i];
      allow <= (sels[i][7:0] == CPED_EV_L2_OWN);
      rd_chk(CPED_OFF_STATUS, {30'h0, halted, sup(sels[i][7:0], sels[i][15:8])});
      run <= 1'b1;
      repeat (40) @(posedge clk);
      run <= 1'b0;
      repeat (4) @(posedge clk);
      rd_chk(CPED_OFF_COUNT, cnt_exp - base);
    end
    tally_and_finish();
  end
endmodule

`default_nettype wire
